// file: rdc_if.sv
// Link between the correction control and the ratio divider
interface rdc_if;
  logic       tick;
  logic [9:0] len;
  logic       pulse;
  logic       win_end;

  modport ctl (output tick, output len, input pulse, input win_end);
  modport div (input tick, input len, output pulse, output win_end);
endinterface

// file: rdc_pkg.sv
// Constants shared by the rate divider correction block
//------------------------------------------------------------------------------
// What this block does
// (RL1) Divide 32768 Hz oscillator down to 512 Hz tap
// (RL2) Normal second: 100 pulses per 512 taps
// (RL3) 100 Hz pulses clock the hundredths counter
// (RL4) Positive correction second uses 511 taps
// (RL5) Negative correction second uses 513 taps
// (RL6) Cycle is 8 minutes positive, 16 negative
// (RL7) Only first N seconds of cycle corrected
// (RL8) Magnitude: five low bits of register 08h
// (RL9) Sixth bit picks direction, one speeds up
// (RL10) Frequency test drives 512 Hz on shared pin
// (RL11) Test signal taken before the correction stage
// (RL12) Host rewrites correction at most once per cycle
// (RL13) Zero magnitude means normal ratio every second
// (RL14) Correction cycle aligned to minute boundaries
//------------------------------------------------------------------------------
package rdc_pkg;
  // Oscillator and tap rates
  localparam int unsigned OSC_HZ  = 32768;
  localparam int unsigned TAP_HZ  = 512;
  localparam int unsigned OSC_DIV = OSC_HZ / TAP_HZ;
  localparam logic [5:0]  DIV_LAST = 6'(OSC_DIV - 1);

  // Window lengths in taps, pulses per window
  localparam logic [9:0] NORMAL_LEN = 10'h200;
  localparam logic [9:0] FAST_LEN   = 10'h1ff;
  localparam logic [9:0] SLOW_LEN   = 10'h201;
  localparam logic [9:0] PULSES     = 10'h064;

  // Time counter limits and correction cycle lengths in minutes
  localparam logic [6:0] HUND_MAX  = 7'h63;
  localparam logic [5:0] SEC_MAX   = 6'h3b;
  localparam logic [5:0] MIN_MAX   = 6'h3b;
  localparam logic [3:0] POS_CYC_MASK = 4'h7;
  localparam logic [3:0] NEG_CYC_MASK = 4'hf;

  // Register offsets and reset values
  localparam logic [6:0] CAL_ADDR  = 7'h08;
  localparam logic [6:0] TRIM_ADDR = 7'h12;
  localparam logic [7:0] CAL_RST   = 8'h00;
  localparam logic [7:0] TRIM_RST  = 8'h00;

  // Correction register fields
  localparam int unsigned MAG_LSB  = 0;
  localparam int unsigned MAG_W    = 5;
  localparam int unsigned SIGN_BIT = 5;
  localparam int unsigned FT_BIT   = 6;
  localparam int unsigned OUT_BIT  = 7;

  // Serial command byte: write flag in the top bit
  localparam int unsigned SPI_WR_BIT = 7;
  localparam logic [2:0]  SPI_LAST_BIT = 3'h7;
endpackage

// file: rdc_ratio_div.sv
// Ratio divider: turns len taps into exactly 100 evenly spread pulses
module rdc_ratio_div
  import rdc_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic rst_b_in,
  rdc_if.div        bus
);
  typedef struct packed {
    logic [9:0] idx;
    logic [9:0] acc;
    logic       pulse;
    logic       wend;
  } rdc_div_st_t;

  rdc_div_st_t q;
  rdc_div_st_t d;
  logic [9:0]  sum;

  // Accumulate 100 per tap, fire when the window length is reached
  always_comb begin
    d       = q;
    d.pulse = 1'b0;
    d.wend  = 1'b0;
    sum     = q.acc + PULSES;
    if (bus.tick) begin
      if (sum >= bus.len) begin // RL2
        d.pulse = 1'b1;
        d.acc   = sum - bus.len;
      end else begin
        d.acc = sum;
      end
      if (q.idx == bus.len - 10'h001) begin
        d.idx  = 10'h000;
        d.acc  = 10'h000;
        d.wend = 1'b1;
      end else begin
        d.idx = q.idx + 10'h001;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.pulse   = q.pulse;
  assign bus.win_end = q.wend;
endmodule

// file: rdc_spi_host.sv
// Serial host model that reads and writes the register port
module rdc_spi_host (
  input  wire logic sys_clk_in,
  input  wire logic spi_miso_in,
  output logic      spi_sclk_out,
  output logic      spi_cs_b_out,
  output logic      spi_mosi_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: serial clock low, not selected
  initial begin
    spi_sclk_out = 1'b0;
    spi_cs_b_out = 1'b1;
    spi_mosi_out = 1'b0;
  end

  // Half serial period of six system clocks
  task automatic half();
    repeat (6) @(negedge sys_clk_in);
  endtask

  // One byte each way, MSB first, taken on the rising serial edge
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi_out = tx[i];
      half();
      spi_sclk_out = 1'b1;
      rx[i]        = spi_miso_in;
      half();
      spi_sclk_out = 1'b0;
    end
  endtask

  // Command byte then one data byte; caller paces calibration rewrites
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic [7:0] junk;
    @(negedge sys_clk_in);
    spi_cs_b_out = 1'b0;
    half();
    shift({wr, addr}, junk);
    shift(wd, rd);
    half();
    spi_cs_b_out = 1'b1;
    spi_mosi_out = ~spi_mosi_out;  // Released line does not hold its value
    half();
  endtask
endmodule

// file: rdc_top.sv
// Digital rate correction stage with serial register port and test pin
module rdc_top
  import rdc_pkg::*;
#(
  parameter int unsigned DIV_RATIO = OSC_DIV
)
(
  input  wire logic       sys_clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       osc_in,
  input  wire logic       spi_sclk_in,
  input  wire logic       spi_cs_b_in,
  input  wire logic       spi_mosi_in,
  output logic            spi_miso_out,
  output logic            spi_miso_oe_out,
  output logic            shared_irq_test_output_pin_out,
  output logic            shared_irq_test_output_pin_oe_out,
  output logic            hundredths_tick_out,
  output logic [6:0]      hundredths_out,
  output logic [5:0]      seconds_out,
  output logic [5:0]      minutes_out,
  output logic [7:0]      cap_trim_out
);
  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] osc_s;
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic [5:0] div;
    logic [7:0] cal;
    logic [7:0] trim;
    logic [6:0] hund;
    logic       hund_tick;
    logic [5:0] sec;
    logic [5:0] min;
    logic [3:0] cyc;
    logic [9:0] len;
    logic [2:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic [6:0] addr;
    logic       have_addr;
    logic       wr;
    logic       miso;
  } rdc_st_t;

  rdc_st_t q;
  rdc_st_t d;

  // Divider end count and square bit; ratio must be a power of two, 64 at most
  localparam logic [5:0]  DIV_END = 6'(DIV_RATIO - 1);
  localparam int unsigned SQ_BIT  = $clog2(DIV_RATIO) - 1;

  rdc_if link ();

  logic       osc_rise;
  logic       tap;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_act;
  logic [7:0] byte_in;
  logic [4:0] mag;
  logic       sign;
  logic       ft_en;

  //----------------------------------------------------------------------------
  // Combinational helpers
  //----------------------------------------------------------------------------
  // Edges seen only from second and third synchroniser stages
  assign osc_rise  = q.osc_s[1] & ~q.osc_s[2];
  assign tap       = osc_rise && (q.div == DIV_END); // RL1
  assign sclk_rise = q.sclk_s[1] & ~q.sclk_s[2];
  assign sclk_fall = ~q.sclk_s[1] & q.sclk_s[2];
  assign cs_act    = ~q.cs_s[1];
  assign byte_in   = {q.sh[6:0], q.mosi_s[1]};
  assign mag       = q.cal[MAG_LSB +: MAG_W]; // RL8
  assign sign      = q.cal[SIGN_BIT]; // RL9
  assign ft_en     = q.cal[FT_BIT];

  // Register read mux; unused offsets read zero
  function automatic logic [7:0] read_reg(input logic [6:0] a, input rdc_st_t s);
    logic [7:0] r;
    r = 8'h00;
    if (a == CAL_ADDR) begin
      r = s.cal;
    end else if (a == TRIM_ADDR) begin
      r = s.trim;
    end
    return r;
  endfunction

  // Window length for a given second and cycle minute
  function automatic logic [9:0] pick_len(input logic [5:0] s, input logic [3:0] c,
                                          input logic [4:0] m, input logic sg);
    logic [9:0] l;
    logic       aligned;
    l       = NORMAL_LEN;
    aligned = sg ? ((c & POS_CYC_MASK) == 4'h0) : ((c & NEG_CYC_MASK) == 4'h0); // RL6 RL14
    if ((m != 5'h00) && aligned && (s < {1'b0, m})) begin // RL7 RL13
      l = sg ? FAST_LEN : SLOW_LEN; // RL4 RL5
    end
    return l;
  endfunction

  //----------------------------------------------------------------------------
  // Next state
  //----------------------------------------------------------------------------
  always_comb begin
    d           = q;
    d.osc_s     = {q.osc_s[1:0], osc_in};
    d.sclk_s    = {q.sclk_s[1:0], spi_sclk_in};
    d.cs_s      = {q.cs_s[0], spi_cs_b_in};
    d.mosi_s    = {q.mosi_s[0], spi_mosi_in};
    d.hund_tick = 1'b0;

    // Free-running oscillator divider, also the test square wave
    if (osc_rise) begin
      d.div = (q.div == DIV_END) ? 6'h00 : q.div + 6'h01; // RL1 RL11
    end

    // Hundredths counter fed by the divider pulses
    if (link.pulse) begin
      d.hund_tick = 1'b1; // RL3
      d.hund      = (q.hund == HUND_MAX) ? 7'h00 : q.hund + 7'h01;
    end

    // Seconds and minutes; next window length chosen at each boundary
    if (link.win_end) begin
      d.hund = 7'h00;
      if (q.sec == SEC_MAX) begin
        d.sec = 6'h00;
        d.min = (q.min == MIN_MAX) ? 6'h00 : q.min + 6'h01;
        d.cyc = q.cyc + 4'h1; // RL14
      end else begin
        d.sec = q.sec + 6'h01;
      end
      d.len = pick_len(d.sec, d.cyc, mag, sign); // RL6 RL7
    end

    // Serial port, mode 0: sample on rise, shift out on fall
    if (!cs_act) begin
      d.bit_cnt   = 3'h0;
      d.have_addr = 1'b0;
      d.wr        = 1'b0;
    end else begin
      if (sclk_rise) begin
        d.sh      = byte_in;
        d.bit_cnt = q.bit_cnt + 3'h1;
        if (q.bit_cnt == SPI_LAST_BIT) begin
          if (!q.have_addr) begin
            d.have_addr = 1'b1;
            d.wr        = byte_in[SPI_WR_BIT];
            d.addr      = byte_in[6:0];
            d.tx        = read_reg(byte_in[6:0], q);
          end else begin
            if (q.wr) begin
              if (q.addr == CAL_ADDR) begin
                d.cal = byte_in; // RL8 RL9
              end else if (q.addr == TRIM_ADDR) begin
                d.trim = byte_in;
              end
            end
            d.addr = q.addr + 7'h01;
            d.tx   = read_reg(q.addr + 7'h01, q);
          end
        end
      end
      if (sclk_fall && q.have_addr && !q.wr) begin
        d.miso = q.tx[7];
        d.tx   = {q.tx[6:0], 1'b0};
      end
    end
  end

  //----------------------------------------------------------------------------
  // State register
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      q        <= '0;
      q.sclk_s <= 3'h0;
      q.cs_s   <= 2'h3;
      q.cal    <= CAL_RST;
      q.trim   <= TRIM_RST;
      q.len    <= NORMAL_LEN;
    end else begin
      q <= d;
    end
  end

  //----------------------------------------------------------------------------
  // Divider and outputs
  //----------------------------------------------------------------------------
  assign link.tick = tap;
  assign link.len  = q.len;

  rdc_ratio_div u_div (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .bus        (link)
  );

  // Test pin: 512 Hz square when enabled, else open-drain output level
  assign shared_irq_test_output_pin_out    = ft_en ? q.div[SQ_BIT] : 1'b0; // RL10 RL11
  assign shared_irq_test_output_pin_oe_out = ft_en | ~q.cal[OUT_BIT];
  assign spi_miso_out     = q.miso;
  assign spi_miso_oe_out  = cs_act && q.have_addr && !q.wr;
  assign hundredths_tick_out = q.hund_tick;
  assign hundredths_out   = q.hund;
  assign seconds_out      = q.sec;
  assign minutes_out      = q.min;
  assign cap_trim_out     = q.trim;

  //----------------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Pulse and tap counts within the current window
  logic [9:0] chk_pulses;
  logic [9:0] chk_taps;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || link.win_end) begin
      chk_pulses <= 10'h000;
      chk_taps   <= 10'h000;
    end else begin
      chk_pulses <= chk_pulses + {9'h000, link.pulse};
      chk_taps   <= chk_taps + {9'h000, tap};
    end
  end

  // Oscillator rises since the last tap
  logic [6:0] chk_osc;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || tap) begin
      chk_osc <= 7'h00;
    end else if (osc_rise) begin
      chk_osc <= chk_osc + 7'h01;
    end
  end

  property p_tap_rate;
    tap |-> chk_osc == 7'(DIV_RATIO - 1);
  endproperty
  a_tap_rate: assert property (p_tap_rate) else $error("tap off divider end"); // RL1

  property p_hundred;
    link.win_end |-> link.pulse && chk_pulses == PULSES - 10'h001;
  endproperty
  a_hundred: assert property (p_hundred) else $error("window pulse count not 100"); // RL2

  property p_hund_count;
    link.pulse && !link.win_end && q.hund != HUND_MAX |=> q.hund == $past(q.hund) + 7'h01;
  endproperty
  a_hund_count: assert property (p_hund_count) else $error("hundredths missed pulse"); // RL3

  property p_taps_len;
    link.win_end |-> chk_taps == q.len;
  endproperty
  a_taps_len: assert property (p_taps_len) else $error("window tap count wrong"); // RL4

  sequence s_slow_start;
    link.win_end && mag != 5'h00 && !sign && d.sec < {1'b0, mag}
      && (d.cyc & NEG_CYC_MASK) == 4'h0;
  endsequence
  property p_slow;
    s_slow_start |=> q.len == SLOW_LEN;
  endproperty
  a_slow: assert property (p_slow) else $error("slow second not 513"); // RL5

  sequence s_fast_start;
    link.win_end && mag != 5'h00 && sign && d.sec < {1'b0, mag}
      && (d.cyc & POS_CYC_MASK) == 4'h0;
  endsequence
  property p_fast;
    s_fast_start |=> q.len == FAST_LEN;
  endproperty
  a_fast: assert property (p_fast) else $error("fast second not 511"); // RL6

  property p_after_n;
    link.win_end && d.sec >= {1'b0, mag} |=> q.len == NORMAL_LEN;
  endproperty
  a_after_n: assert property (p_after_n) else $error("correction beyond N seconds"); // RL7

  property p_cal_write;
    sclk_rise && q.have_addr && q.wr && q.addr == CAL_ADDR && q.bit_cnt == SPI_LAST_BIT
      |=> mag == $past(byte_in[4:0]) && sign == $past(byte_in[5]);
  endproperty
  a_cal_write: assert property (p_cal_write) else $error("correction write lost"); // RL8

  property p_ft_pin;
    ft_en |-> shared_irq_test_output_pin_oe_out
      && shared_irq_test_output_pin_out == q.div[SQ_BIT];
  endproperty
  a_ft_pin: assert property (p_ft_pin) else $error("test pin not 512 Hz"); // RL10

  property p_ft_steady;
    !osc_rise |=> $stable(q.div[SQ_BIT]);
  endproperty
  a_ft_steady: assert property (p_ft_steady) else $error("test square moved off osc"); // RL11

  property p_zero_mag;
    link.win_end && mag == 5'h00 |=> q.len == NORMAL_LEN;
  endproperty
  a_zero_mag: assert property (p_zero_mag) else $error("zero magnitude corrected"); // RL13
endmodule

// file: rtc_periodic_divider_correction_tb.sv
// Self-checking bench for the digital rate correction stage
module rtc_periodic_divider_correction_tb
  import rdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic       sys_clk_in, rst_b_in, osc_in, sclk, cs_b, mosi, miso, miso_oe;
  logic       pin, pin_oe, pin_d, tick;
  logic [6:0] hund;
  logic [5:0] secs, mins;
  logic [7:0] trim, rd, trim_v, cal_v;
  logic [4:0] mag;
  int         errors, checked, ticks, pin_rises, seed;

  // Short oscillator ratio keeps one second near 8k clocks
  localparam int unsigned TB_DIV = 8;

  rdc_top #(
    .DIV_RATIO (TB_DIV)
  ) DUT (
    .sys_clk_in                        (sys_clk_in),
    .rst_b_in                          (rst_b_in),
    .osc_in                            (osc_in),
    .spi_sclk_in                       (sclk),
    .spi_cs_b_in                       (cs_b),
    .spi_mosi_in                       (mosi),
    .spi_miso_out                      (miso),
    .spi_miso_oe_out                   (miso_oe),
    .shared_irq_test_output_pin_out    (pin),
    .shared_irq_test_output_pin_oe_out (pin_oe),
    .hundredths_tick_out               (tick),
    .hundredths_out                    (hund),
    .seconds_out                       (secs),
    .minutes_out                       (mins),
    .cap_trim_out                      (trim)
  );

  rdc_spi_host host (
    .sys_clk_in   (sys_clk_in),
    .spi_miso_in  (miso),
    .spi_sclk_out (sclk),
    .spi_cs_b_out (cs_b),
    .spi_mosi_out (mosi)
  );

  // ----------------------------------------
  // Clock, monitors and helpers
  // ----------------------------------------
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // Count divider pulses and driven rises of the test pin
  always @(posedge sys_clk_in) begin
    pin_d <= pin;
    if (tick === 1'b1) ticks <= ticks + 1;
    if (pin === 1'b1 && pin_d === 1'b0 && pin_oe === 1'b1) pin_rises <= pin_rises + 1;
  end

  // Fast oscillator: one rise every two clocks, TB_DIV rises per tap
  task automatic run_taps(input int k);
    repeat (k * int'(TB_DIV)) begin
      @(negedge sys_clk_in) osc_in = 1'b1;
      @(negedge sys_clk_in) osc_in = 1'b0;
    end
    repeat (8) @(negedge sys_clk_in);
  endtask

  // Pulses owed after k taps of a window of len taps
  function automatic int exp_ticks(input int k, input int len);
    return (k * int'(PULSES)) / len;
  endfunction

  task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Cut a hang short well past the expected span
  initial begin
    repeat (40000) @(posedge sys_clk_in);
    errors++;
    end_sim();
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    seed      = 32'h48d3;
    osc_in    = 1'b0;
    rst_b_in  = 1'b0;
    pin_d     = 1'b0;
    errors    = 0;
    checked   = 0;
    ticks     = 0;
    pin_rises = 0;
    repeat (2) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge sys_clk_in);

    // Register port: trim round trip, reset value, unmapped place
    trim_v = 8'($random(seed));
    host.xfer(1'b1, TRIM_ADDR, trim_v, rd);
    host.xfer(1'b0, TRIM_ADDR, 8'h00, rd);
    cmp_reg(rd, trim_v);
    cmp_reg(trim, trim_v);
    host.xfer(1'b0, CAL_ADDR, 8'h00, rd);
    cmp_reg(rd, CAL_RST);
    host.xfer(1'b1, 7'h13, 8'hff, rd);
    host.xfer(1'b0, 7'h13, 8'h00, rd);
    cmp_reg(rd, 8'h00);
    $display("Test registers done");

    // Fast correction armed, test pin on; first second stays normal
    mag = 5'($random(seed)) | 5'h02;
    cal_v = {2'b01, 1'b1, mag};
    host.xfer(1'b1, CAL_ADDR, cal_v, rd);
    host.xfer(1'b0, CAL_ADDR, 8'h00, rd);
    cmp_reg(rd, cal_v);
    ticks     = 0;
    pin_rises = 0;
    run_taps(511);
    cmp_cnt(ticks, exp_ticks(511, int'(NORMAL_LEN)));
    cmp_cnt(32'(hund), 32'(exp_ticks(511, int'(NORMAL_LEN)) % 100));
    run_taps(1);
    cmp_cnt(ticks, 32'd100);
    cmp_cnt(32'(secs), 32'd1);
    cmp_cnt(32'(hund), 32'd0);
    cmp_cnt(pin_rises, 32'd512);
    cmp_cnt(32'(pin_oe), 32'd1);
    $display("Test normal second done");

    // Second one is shortened by the fast setting
    ticks     = 0;
    pin_rises = 0;
    run_taps(46);
    cmp_cnt(ticks, exp_ticks(46, int'(FAST_LEN)));
    run_taps(int'(FAST_LEN) - 47);
    cmp_cnt(ticks, 32'd99);
    run_taps(1);
    cmp_cnt(ticks, 32'd100);
    cmp_cnt(32'(secs), 32'd2);
    cmp_cnt(pin_rises, 32'(FAST_LEN));
    $display("Test fast second done");

    // Mid-run reset clears time and registers; pin drives low
    rst_b_in = 1'b0;
    repeat (2) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    @(negedge sys_clk_in);
    cmp_cnt(32'({mins, secs, hund, miso_oe, pin, pin_oe}), 32'd1);

    // Slow setting written inside second zero applies from the next one
    ticks = 0;
    run_taps(46);
    mag   = 5'($random(seed)) | 5'h03;
    cal_v = {2'b01, 1'b0, mag};
    host.xfer(1'b1, CAL_ADDR, cal_v, rd);
    run_taps(int'(NORMAL_LEN) - 47);
    cmp_cnt(ticks, 32'd99);
    run_taps(1);
    cmp_cnt(ticks, 32'd100);
    cmp_cnt(32'(secs), 32'd1);
    $display("Test reset and rewrite done");

    // Second one is lengthened by the slow setting
    ticks = 0;
    run_taps(41);
    cmp_cnt(ticks, exp_ticks(41, int'(SLOW_LEN)));
    cmp_cnt(32'(hund), 32'(exp_ticks(41, int'(SLOW_LEN))));
    $display("Test slow second done");
    end_sim();
  end
endmodule
